// ---- rtl/rpmc_pkg.sv ----
// Constants and types shared by the reduced power mode controller.
// Assumes a 10 MHz oscillator clock and an 8-bit special function register bus.
package rpmc_pkg;

    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;

    localparam int BIT_IDLE_REQ   = 0;
    localparam int BIT_PDOWN_REQ  = 1;
    localparam int BIT_SOFT_FLAG0 = 2;
    localparam int BIT_SOFT_FLAG1 = 3;
    localparam int BIT_BAUD_DBL   = 7;

    // Bits that hold storage; bits 6 to 4 are reserved and read as zero.
    localparam logic [7:0] POWER_CONTROL_MASK = 8'h8F;

    localparam int CLK_PERIOD_NS      = 100;
    localparam int OSC_PERIOD_NS      = 100;
    // The wake delay and the reset hold are given in oscillator periods.
    localparam int WAKE_DELAY_PERIODS = 1536;
    localparam int RESET_HOLD_PERIODS = 24;
    localparam int WAKE_DELAY_CYCLES  =
        (WAKE_DELAY_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYCLES  =
        (RESET_HOLD_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int WAKE_CNT_W  = 11;
    localparam int RESET_CNT_W = 5;

    typedef enum logic [1:0] {
        RPMC_RUN,
        RPMC_IDLE,
        RPMC_PDOWN,
        RPMC_SETTLE
    } rpmc_mode_e;

endpackage : rpmc_pkg

// ---- rtl/rpmc_cnt_if.sv ----
// Carrier between the mode controller and its counters.
// Assumes both ends run on the same oscillator clock.
`timescale 1ns/10ps
interface rpmc_cnt_if;
    logic start;
    logic run;
    logic done;

    modport ctrl (output start, output run, input done);
    modport cnt  (input start, input run, output done);
endinterface : rpmc_cnt_if

// ---- rtl/rpmc_counter.sv ----
// Down counter that reports when a programmed number of cycles has passed.
// Assumes start is a one-cycle pulse and run is held while counting is wanted.
`timescale 1ns/10ps
module rpmc_counter #(
    parameter int W     = 11,
    parameter int COUNT = 1536
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    rpmc_cnt_if.cnt     bus
);
    localparam logic [W-1:0] LOAD = W'(COUNT - 1);

    logic [W-1:0] count;
    logic         active;
    logic         done;

    assign bus.done = done;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count  <= '0;
            active <= 1'b0;
            done   <= 1'b0;
        end
        else if (bus.start)
        begin
            count  <= LOAD;
            active <= 1'b1;
            done   <= 1'b0;
        end
        else if (!bus.run)
        begin
            active <= 1'b0;
            done   <= 1'b0;
        end
        else if (active)
        begin
            count  <= count - 1'b1;
            active <= (count != '0);
            done   <= (count == '0);
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule : rpmc_counter

// ---- rtl/rpmc_top.sv ----
// Reduced power mode controller: power control register, Idle and Power-down
// sequencing, wake-up, reset qualification and pin states in each mode.
// Assumes the core drives the SFR bus on the oscillator clock; pins are asynchronous.
`timescale 1ns/10ps
module rpmc_top (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       I_RST_PIN,
    input  wire logic       I_T2_OVERFLOW,
    input  wire logic       I_SFR_WR,
    input  wire logic       I_SFR_RD,
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic       I_IRQ_PENDING,
    input  wire logic [7:0] I_WAKE_INT,
    input  wire logic [7:0] I_WAKE_INT_EN,
    input  wire logic       I_EXT_FETCH,
    input  wire logic [7:0] I_PORT0_REG,
    input  wire logic [7:0] I_PORT2_REG,
    input  wire logic [7:0] I_FETCH_ADDR_HI,
    input  wire logic       I_ALE_RUN,
    input  wire logic       I_PROGRAM_STORE_STROBE_RUN,
    output logic [7:0]      O_SFR_RDATA,
    output logic            O_SFR_HIT,
    output logic            O_CPU_CLK_EN,
    output logic            O_PERIPH_CLK_EN,
    output logic            O_OSC_EN,
    output logic            O_SOFT_RESET,
    output logic            O_BAUD_DOUBLE,
    output logic            O_ALE,
    output logic            O_PROGRAM_STORE_STROBE,
    output logic [7:0]      O_PORT0,
    output logic            O_PORT0_OE,
    output logic [7:0]      O_PORT2,
    output logic            O_IDLE,
    output logic            O_POWERDOWN
);
    rpmc_pkg::rpmc_mode_e mode;
    rpmc_pkg::rpmc_mode_e next_mode;

    logic [7:0] power_control_reg;
    logic [7:0] next_power_control;
    logic       rst_pin_s1;
    logic       rst_pin_s2;
    logic       rst_pin_q;
    logic [7:0] wake_s1;
    logic [7:0] wake_s2;
    logic       pd_ext_fetch;

    rpmc_cnt_if wake_cnt ();
    rpmc_cnt_if hold_cnt ();

    rpmc_counter #(
        .W     (rpmc_pkg::WAKE_CNT_W),
        .COUNT (rpmc_pkg::WAKE_DELAY_CYCLES)
    ) u_wake_delay (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .bus     (wake_cnt.cnt)
    );

    rpmc_counter #(
        .W     (rpmc_pkg::RESET_CNT_W),
        .COUNT (rpmc_pkg::RESET_HOLD_CYCLES)
    ) u_reset_hold (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .bus     (hold_cnt.cnt)
    );

    // Pins from outside the clock domain pass two flops before use.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_pin_s1 <= 1'b0;
            rst_pin_s2 <= 1'b0;
            rst_pin_q  <= 1'b0;
            wake_s1    <= 8'h00;
            wake_s2    <= 8'h00;
        end
        else
        begin
            rst_pin_s1 <= I_RST_PIN;
            rst_pin_s2 <= rst_pin_s1;
            rst_pin_q  <= rst_pin_s2;
            wake_s1    <= I_WAKE_INT;
            wake_s2    <= wake_s1;
        end
    end

    // Decode of the byte-wide register access; no bit addressing exists.
    wire power_control_sel   = (I_SFR_ADDR == rpmc_pkg::POWER_CONTROL_ADDR);
    wire power_control_wr    = I_SFR_WR && power_control_sel && (mode == rpmc_pkg::RPMC_RUN);
    wire wr_pdown   = power_control_wr && I_SFR_WDATA[rpmc_pkg::BIT_PDOWN_REQ];
    wire wr_idle    = power_control_wr && I_SFR_WDATA[rpmc_pkg::BIT_IDLE_REQ];
    wire wake_fire  = |(wake_s2 & I_WAKE_INT_EN);
    // The reset pin counts as held only after it stays high for the full hold.
    wire pin_reset  = hold_cnt.done;
    wire any_reset  = pin_reset || I_T2_OVERFLOW;

    // The rise of the pin, not its level, starts the hold count, so a held pin resets once.
    assign hold_cnt.start = rst_pin_s2 && !rst_pin_q;
    assign hold_cnt.run   = rst_pin_s2;
    assign wake_cnt.start = (mode == rpmc_pkg::RPMC_PDOWN) && wake_fire;
    assign wake_cnt.run   = (mode == rpmc_pkg::RPMC_SETTLE) || wake_cnt.start;

    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            rpmc_pkg::RPMC_RUN:
            begin
                if (wr_pdown)
                    next_mode = rpmc_pkg::RPMC_PDOWN;
                else if (wr_idle)
                    next_mode = rpmc_pkg::RPMC_IDLE;
            end
            rpmc_pkg::RPMC_IDLE:
            begin
                if (I_IRQ_PENDING)
                    next_mode = rpmc_pkg::RPMC_RUN;
            end
            rpmc_pkg::RPMC_PDOWN:
            begin
                if (wake_fire)
                    next_mode = rpmc_pkg::RPMC_SETTLE;
            end
            rpmc_pkg::RPMC_SETTLE:
            begin
                if (wake_cnt.done)
                    next_mode = rpmc_pkg::RPMC_RUN;
            end
        endcase
        if (any_reset)
            next_mode = rpmc_pkg::RPMC_RUN;
    end

    always_comb
    begin
        next_power_control = power_control_reg;
        if (power_control_wr)
            next_power_control = I_SFR_WDATA & rpmc_pkg::POWER_CONTROL_MASK;
        if (mode == rpmc_pkg::RPMC_IDLE && I_IRQ_PENDING)
            next_power_control[rpmc_pkg::BIT_IDLE_REQ] = 1'b0;
        if (mode == rpmc_pkg::RPMC_SETTLE && wake_cnt.done)
            next_power_control[rpmc_pkg::BIT_PDOWN_REQ] = 1'b0;
        if (any_reset)
            next_power_control = rpmc_pkg::POWER_CONTROL_RST;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            mode              <= rpmc_pkg::RPMC_RUN;
            power_control_reg <= rpmc_pkg::POWER_CONTROL_RST;
        end
        else
        begin
            mode              <= next_mode;
            power_control_reg <= next_power_control;
        end
    end

    // External fetch state is caught on entry so port 2 restores correctly.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            pd_ext_fetch <= 1'b0;
        else if (mode == rpmc_pkg::RPMC_RUN)
            pd_ext_fetch <= I_EXT_FETCH;
    end

    wire in_idle  = (next_mode == rpmc_pkg::RPMC_IDLE);
    wire in_pdown = (next_mode == rpmc_pkg::RPMC_PDOWN);
    wire in_sleep = in_pdown || (next_mode == rpmc_pkg::RPMC_SETTLE);
    wire ext_mem  = (next_mode == rpmc_pkg::RPMC_RUN) ? I_EXT_FETCH : pd_ext_fetch;

    // Port 2 carries the address only while fetching and not in Power-down.
    wire [7:0] port2_val = (ext_mem && !in_sleep) ? I_FETCH_ADDR_HI
                                                  : I_PORT2_REG;
    wire       ale_val   = in_sleep ? 1'b0 : (in_idle ? 1'b1 : I_ALE_RUN);
    wire       program_store_strobe_val  = in_sleep ? 1'b0 : (in_idle ? 1'b1 : I_PROGRAM_STORE_STROBE_RUN);

    // Read data is zero on a miss, so the core can OR several register sources together.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_SFR_RDATA <= 8'h00;
            O_SFR_HIT   <= 1'b0;
        end
        else
        begin
            O_SFR_RDATA <= (I_SFR_RD && power_control_sel) ? power_control_reg : 8'h00;
            O_SFR_HIT   <= power_control_sel && (I_SFR_RD || I_SFR_WR);
        end
    end

    // The enables follow the next mode, so they switch on the same edge as the mode.
    // Peripherals keep their clock through Idle and stop in Power-down and while settling after a wake.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_CPU_CLK_EN    <= 1'b1;
            O_PERIPH_CLK_EN <= 1'b1;
            O_OSC_EN        <= 1'b1;
        end
        else
        begin
            O_CPU_CLK_EN    <= (next_mode == rpmc_pkg::RPMC_RUN);
            O_PERIPH_CLK_EN <= !in_sleep;
            O_OSC_EN        <= !in_pdown;
        end
    end

    // A reset event is passed on so the other special function registers reinitialise too.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_SOFT_RESET  <= 1'b0;
            O_BAUD_DOUBLE <= 1'b0;
        end
        else
        begin
            O_SOFT_RESET  <= any_reset;
            O_BAUD_DOUBLE <= next_power_control[rpmc_pkg::BIT_BAUD_DBL];
        end
    end

    // Strobes are forced in the low power modes and pass through from the core in run.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_ALE                  <= 1'b0;
            O_PROGRAM_STORE_STROBE <= 1'b0;
        end
        else
        begin
            O_ALE                  <= ale_val;
            O_PROGRAM_STORE_STROBE <= program_store_strobe_val;
        end
    end

    // Port 0 lets go of its pins while the address bus belongs to external fetch.
    // Port 2 keeps its register value in Power-down even when fetch was external.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_PORT0    <= 8'h00;
            O_PORT0_OE <= 1'b0;
            O_PORT2    <= 8'h00;
        end
        else
        begin
            O_PORT0    <= I_PORT0_REG;
            O_PORT0_OE <= !ext_mem;
            O_PORT2    <= port2_val;
        end
    end

    // Settling after a wake still counts as Power-down to the outside world.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_IDLE      <= 1'b0;
            O_POWERDOWN <= 1'b0;
        end
        else
        begin
            O_IDLE      <= in_idle;
            O_POWERDOWN <= in_sleep;
        end
    end
endmodule : rpmc_top

// ---- tb/rpmc_top_properties.sv ----
// Concurrent checks on the port behaviour of the reduced power mode controller.
// Assumes it is bound onto rpmc_top, with one oscillator clock and an async reset.
`timescale 1ns/10ps
module rpmc_checker (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       I_SFR_WR,
    input  wire logic       I_SFR_RD,
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic       I_IRQ_PENDING,
    input  wire logic       I_T2_OVERFLOW,
    input  wire logic [7:0] O_SFR_RDATA,
    input  wire logic       O_SFR_HIT,
    input  wire logic       O_CPU_CLK_EN,
    input  wire logic       O_PERIPH_CLK_EN,
    input  wire logic       O_OSC_EN,
    input  wire logic       O_BAUD_DOUBLE,
    input  wire logic       O_ALE,
    input  wire logic       O_PROGRAM_STORE_STROBE,
    input  wire logic       O_IDLE,
    input  wire logic       O_POWERDOWN
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    // Writes count only in run; writes in a low power mode are refused.
    wire logic run_wr = I_SFR_WR && (I_SFR_ADDR == 8'h87) && O_CPU_CLK_EN && !O_IDLE
                        && !O_POWERDOWN && !I_T2_OVERFLOW;

    idle_entry_a: assert property (run_wr && I_SFR_WDATA[1:0] == 2'h1
        |=> O_IDLE && !O_CPU_CLK_EN) else $error("idle not entered after write");
    pd_entry_a: assert property (run_wr && I_SFR_WDATA[1]
        |=> O_POWERDOWN && !O_IDLE && !O_OSC_EN) else $error("power-down not entered");
    idle_clocks_a: assert property (O_IDLE
        |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN && O_OSC_EN) else $error("idle clocks wrong");
    idle_strobes_a: assert property (O_IDLE
        |-> O_ALE && O_PROGRAM_STORE_STROBE) else $error("idle strobes not high");
    pd_pins_a: assert property (O_POWERDOWN
        |-> !O_ALE && !O_PROGRAM_STORE_STROBE && !O_CPU_CLK_EN) else $error("pd pins wrong");
    irq_wake_a: assert property (O_IDLE && I_IRQ_PENDING
        |=> !O_IDLE && O_CPU_CLK_EN) else $error("interrupt did not end idle");
    t2_exit_a: assert property (O_IDLE && I_T2_OVERFLOW
        |-> ##[1:4] !O_IDLE) else $error("timer overflow did not end idle");
    baud_track_a: assert property (run_wr
        |=> O_BAUD_DOUBLE == $past(I_SFR_WDATA[7])) else $error("baud bit not stored");
    rd_reserved_a: assert property (I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == 8'h87
        |=> O_SFR_HIT && O_SFR_RDATA[6:4] == 3'h0) else $error("reserved bits not zero");
    rd_miss_a: assert property (I_SFR_RD && !I_SFR_WR && I_SFR_ADDR != 8'h87
        |=> !O_SFR_HIT && O_SFR_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule : rpmc_checker

bind rpmc_top rpmc_checker chk_u (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
    .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_ADDR(I_SFR_ADDR),
    .I_SFR_WDATA(I_SFR_WDATA), .I_IRQ_PENDING(I_IRQ_PENDING), .I_T2_OVERFLOW(I_T2_OVERFLOW),
    .O_SFR_RDATA(O_SFR_RDATA), .O_SFR_HIT(O_SFR_HIT), .O_CPU_CLK_EN(O_CPU_CLK_EN),
    .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_OSC_EN(O_OSC_EN), .O_BAUD_DOUBLE(O_BAUD_DOUBLE),
    .O_ALE(O_ALE), .O_PROGRAM_STORE_STROBE(O_PROGRAM_STORE_STROBE), .O_IDLE(O_IDLE),
    .O_POWERDOWN(O_POWERDOWN));

// ---- tb/rpmc_top_tb.sv ----
// Self-checking bench for the reduced power mode controller.
// Assumes rpmc_top with its checker bound; the bench drives every port itself.
`timescale 1ns/10ps
module rpmc_top_tb;
    logic       clk = 1'h0;
    logic       rst_n, rst_pin, t2, wr, rd, irq, ext, ale_run, program_store_strobe_run;
    logic [7:0] addr, wdata, wake, wake_en, p0, p2, ahi, d, e;
    logic       hit, cpu_en, per_en, osc_en, srst, baud, ale, program_store_strobe, port0_oe, idle, pdown;
    logic [7:0] rdata, port0, port2;
    int         n_fail = 0, n_tests = 0, n, seed = 32'h5bf4;

    always #50 clk = ~clk;

    rpmc_top dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_RST_PIN(rst_pin),
        .I_T2_OVERFLOW(t2), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_ADDR(addr),
        .I_SFR_WDATA(wdata), .I_IRQ_PENDING(irq), .I_WAKE_INT(wake), .I_WAKE_INT_EN(wake_en),
        .I_EXT_FETCH(ext), .I_PORT0_REG(p0), .I_PORT2_REG(p2), .I_FETCH_ADDR_HI(ahi),
        .I_ALE_RUN(ale_run), .I_PROGRAM_STORE_STROBE_RUN(program_store_strobe_run), .O_SFR_RDATA(rdata), .O_SFR_HIT(hit),
        .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_OSC_EN(osc_en),
        .O_SOFT_RESET(srst), .O_BAUD_DOUBLE(baud), .O_ALE(ale), .O_PROGRAM_STORE_STROBE(program_store_strobe),
        .O_PORT0(port0), .O_PORT0_OE(port0_oe), .O_PORT2(port2), .O_IDLE(idle),
        .O_POWERDOWN(pdown));

    function automatic logic [7:0] exp_reg(input logic [7:0] v);
        return v & 8'h8f;
    endfunction : exp_reg

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        v = rdata;
    endtask : rd_reg

    // Waits, bounded, until the core runs again and no reset condition stands.
    task automatic wait_run(input int lim, output int cnt);
        cnt = 0;
        #1;
        while ((cpu_en !== 1'h1 || srst !== 1'h0) && cnt < lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cpu_en !== 1'h1 || srst !== 1'h0)
        begin
            chk({cpu_en, srst}, 16'h0002);
            test_done();
        end
    endtask : wait_run

    initial
    begin
        {rst_n, rst_pin, t2, wr, rd, irq, ext, ale_run, program_store_strobe_run} = '0;
        {addr, wdata, wake, wake_en} = '0;
        p0 = 8'h5a;
        p2 = 8'hc3;
        ahi = 8'h3c;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(8'h87, d);
        chk(d, 8'h00);
        repeat (20)
        begin
            e = $random(seed) & 8'hfc;
            p0 <= $random(seed);
            ale_run <= e[2];
            program_store_strobe_run <= e[3];
            wr_reg(8'h87, e);
            chk(baud, e[7]);
            rd_reg(8'h87, d);
            chk(d, exp_reg(e));
            rd_reg(e, d);
            chk({hit, d}, 8'h00);
        end
        wr_reg(8'h87, 8'h05);
        chk({idle, cpu_en, ale, program_store_strobe}, 8'h0b);
        chk(port0, p0);
        chk({port0_oe, port2}, {1'h1, p2});
        // The fetch source is frozen at Idle entry, so a change during Idle moves no pin.
        @(posedge clk) ext <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({port0_oe, port2}, {1'h1, p2});
        wr_reg(8'h87, 8'h80);
        @(posedge clk) irq <= 1'h1;
        @(posedge clk) irq <= 1'h0;
        ext <= 1'h0;
        wait_run(4, n);
        rd_reg(8'h87, d);
        chk(d, 8'h04);
        ext <= 1'h1;
        wr_reg(8'h87, 8'h81);
        chk(idle, 8'h01);
        chk({port0_oe, port2}, {1'h0, ahi});
        @(posedge clk) t2 <= 1'h1;
        @(posedge clk) t2 <= 1'h0;
        wait_run(60, n);
        rd_reg(8'h87, d);
        chk({baud, d}, 8'h00);
        @(posedge clk) ext <= 1'h1;
        wr_reg(8'h87, 8'h0f);
        chk({pdown, idle, osc_en, ale, program_store_strobe, port0_oe}, 8'h20);
        chk(port2, p2);
        @(posedge clk) wake <= 8'h08;
        wake_en <= 8'h04;
        repeat (20) @(posedge clk);
        #1;
        chk(pdown, 8'h01);
        @(posedge clk) wake_en <= 8'h08;
        wait_run(1700, n);
        chk(n >= 1536 && n <= 1545, 8'h01);
        wake <= 8'h00;
        ext <= 1'h0;
        rd_reg(8'h87, d);
        chk(d & 8'h8e, 8'h0c);
        wr_reg(8'h87, 8'h02);
        chk(pdown, 8'h01);
        // The pin stays high well past the minimum so the oscillator can settle.
        @(posedge clk) rst_pin <= 1'h1;
        repeat (29) @(posedge clk);
        #1;
        chk(osc_en, 8'h01);
        @(posedge clk) rst_pin <= 1'h0;
        wait_run(100, n);
        rd_reg(8'h87, d);
        chk(d, 8'h00);
        test_done();
    end
endmodule : rpmc_top_tb
